// >>> hw/csf_params.svh
// offsets, field positions, reset values and counts of the can status, filter and timing block
`ifndef CSF_PARAMS_SVH
`define CSF_PARAMS_SVH

// ==========================================================
// register indices (byte address = index * 4)
`define CSF_IDX_CTRL      8'h20
`define CSF_IDX_CMD       8'h21
`define CSF_IDX_STAT      8'h22
`define CSF_IDX_IRQ       8'h23
`define CSF_IDX_PATT      8'h24
`define CSF_IDX_MASK      8'h25
`define CSF_IDX_TIMING    8'h26

// ==========================================================
// control_port bits
`define CSF_CTRL_HALT     0
`define CSF_CTRL_RIE      1
`define CSF_CTRL_TIE      2
`define CSF_CTRL_EIE      3
`define CSF_CTRL_OIE      4
`define CSF_CTRL_SPD      6
`define CSF_CTRL_RESET    8'h01

// ==========================================================
// command_port bits (write only, reads all ones)
`define CSF_CMD_SEND      0
`define CSF_CMD_ABORT     1
`define CSF_CMD_RELEASE   2
`define CSF_CMD_CLR_OVR   3
`define CSF_CMD_SLEEP     4
`define CSF_CMD_READ      8'hff

// ==========================================================
// controller_state_flags bits
`define CSF_ST_RBS        0
`define CSF_ST_DO         1
`define CSF_ST_TBA        2
`define CSF_ST_TCS        3
`define CSF_ST_RS         4
`define CSF_ST_TS         5
`define CSF_ST_ES         6
`define CSF_ST_BS         7
`define CSF_STAT_RESET    8'h0c

// ==========================================================
// pending_irq_flags bits
`define CSF_IRQ_RIF       0
`define CSF_IRQ_TIF       1
`define CSF_IRQ_EIF       2
`define CSF_IRQ_OIF       3
`define CSF_IRQ_WIF       4

// ==========================================================
// counts
`define CSF_TEC_OFF       9'd256
`define CSF_WARN_LIMIT    9'd96
`define CSF_RUNS_BUSOFF   8'd128
`define CSF_RUNS_NORMAL   8'd1

`endif

// >>> hw/csf_pkg.sv
// types of the can status, filter and timing block
package csf_pkg;

	// ==========================================================
	// controller phase
	typedef enum logic [1:0] {
		CSF_RUN  = 2'b00,
		CSF_HALT = 2'b01,
		CSF_WAIT = 2'b10
	} csf_phase_t;

	// ==========================================================
	// main block state
	typedef struct packed {
		logic       ack;
		logic [7:0] rdata;
		csf_phase_t phase;
		logic [7:0] runs_left;
		logic       err_reset;
		logic       halt;
		logic       spd;
		logic       overrun_irq_enable;
		logic       error_irq_enable;
		logic       tx_irq_enable;
		logic       rx_irq_enable;
		logic       bus_off;
		logic       warn;
		logic       ts;
		logic       rs;
		logic       send_done_flag;
		logic       tx_buffer_free;
		logic       ovr;
		logic       rx_message_pending;
		logic       wakeup_flag;
		logic       overrun_irq_flag;
		logic       error_irq_flag;
		logic       tx_done_irq_flag;
		logic       rx_irq_flag;
		logic       tx_pending;
		logic       release_cmd;
		logic       sleep;
		logic [1:0] rx_count;
		logic       wr_buf;
		logic       rd_buf;
		logic [7:0] patt;
		logic [7:0] mask;
		logic [7:0] timing;
		logic [2:0] sjw;
		logic       rx_s1;
		logic       rx_s2;
		logic       rx_s3;
		logic       rx_level;
		logic       run;
	} csf_state_t;

	// ==========================================================
	// prescaler state
	typedef struct packed {
		logic [5:0] cnt;
		logic       tq;
	} csf_pre_state_t;

endpackage

// >>> hw/csf_tq_if.sv
// carrier between the status block and its quantum prescaler
`timescale 1ns/1ps
`default_nettype none

interface csf_tq_if;
	logic [5:0] factor;
	logic       run;
	logic       tq;

	modport ctrl (output factor, output run, input tq);
	modport gen  (input factor, input run, output tq);
endinterface

`default_nettype wire

// >>> hw/csf_prescaler.sv
// time quantum prescaler: one enable pulse every factor+1 clocks
`timescale 1ns/1ps
`default_nettype none

module csf_prescaler (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// link to the status block
	csf_tq_if.gen     tq
);

	csf_pkg::csf_pre_state_t s;
	csf_pkg::csf_pre_state_t next_s;

	// ==========================================================
	// reload counter
	always_comb begin
		next_s = s;
		next_s.tq = 1'b0;
		if (!tq.run) begin
			next_s.cnt = tq.factor;
		end else if (s.cnt == 6'h00) begin
			next_s.cnt = tq.factor;
			next_s.tq = 1'b1;
		end else begin
			next_s.cnt = s.cnt - 6'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tq.tq = s.tq;

endmodule

`default_nettype wire

// >>> hw/csf_top.sv
// can controller status, interrupt flags, acceptance filter and quantum timing
//
// Functional notes
// - transmit errors at 256: bus-off, halt, silent
// - after halt cleared, wait 128 runs if bus-off, else 1 run, recover
// - warning while either error counter reaches 96
// - transmit and receive activity flags; both clear idle
// - send request clears done; abort keeps clear
// - pending send locks transmit buffer, writes dropped
// - both buffers full: drop, flag overrun, clear command
// - own outgoing frame occupies a receive buffer; here it only flags overrun at start if both full
// - release clears pending; second buffer resets it
// - interrupt flags read-only, cleared by any read
// - bus activity while asleep: wake, clear sleep
// - overrun interrupt flag, cleared by read or halt
// - error interrupt on warning or bus-off change
// - transmit interrupt at end when buffer free
// - receive interrupt together with receive pending
// - compare identifier bits 10..3 with pattern
// - mask bit one ignores, zero must match
// - rejected frames overwritten, accepted kept if free
// - filter and timing registers reachable only halted
// - resync jump is field plus one quanta
// - quantum prescale factor is field plus one
// - status read-only; reset and halt values
// - halt aborts activity until software releases it
// - release command auto-clears when pending sets
`include "csf_params.svh"
`timescale 1ns/1ps
`default_nettype none

module csf_top (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [9:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// protocol engine events
	input  wire logic [8:0]  tec_i,
	input  wire logic [8:0]  rec_i,
	input  wire logic        tx_start_i,
	input  wire logic        tx_done_i,
	input  wire logic        arb_lost_i,
	input  wire logic        rx_start_i,
	input  wire logic        rx_done_i,
	input  wire logic [10:0] rx_id_i,
	input  wire logic        run11_i,
	// bus pin
	input  wire logic        can_rx_i,
	// protocol engine control
	output logic             halt_o,
	output logic             core_run_o,
	output logic             err_cnt_reset_o,
	output logic             tx_pending_o,
	output logic             tx_buf_open_o,
	output logic             rx_wr_buf_o,
	output logic             rx_rd_buf_o,
	output logic             sleep_o,
	output logic             both_edges_o,
	output logic             tq_pulse_o,
	output logic      [2:0]  sjw_o
);

	csf_pkg::csf_state_t s;
	csf_pkg::csf_state_t next_s;
	csf_tq_if            tq_bus ();

	logic [7:0] idx;
	logic       req;
	logic       wr;
	logic       rd;
	logic [7:0] wbyte;
	logic [7:0] stat_byte;
	logic [7:0] irq_byte;
	logic       accept;
	logic       store;
	logic       rel;
	logic       activity;
	logic       warn_now;
	logic [1:0] cnt_tmp;

	// ==========================================================
	// prescaler
	assign tq_bus.factor = s.timing[5:0];
	assign tq_bus.run    = ~s.sleep;

	csf_prescaler u_pre (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.tq    (tq_bus.gen)
	);

	// ==========================================================
	// combinational helpers
	always_comb begin
		idx   = adr_i[9:2];
		req   = cyc_i & stb_i & ~s.ack;
		wr    = req & we_i & sel_i[0];
		rd    = req & ~we_i;
		wbyte = dat_i[7:0];
		stat_byte = {s.bus_off, s.warn, s.ts, s.rs, s.send_done_flag, s.tx_buffer_free, s.ovr, s.rx_message_pending};
		irq_byte  = {3'b000, s.wakeup_flag, s.overrun_irq_flag, s.error_irq_flag, s.tx_done_irq_flag, s.rx_irq_flag};
		accept = &(~((rx_id_i[10:3] ^ s.patt) & ~s.mask));
		// dominant edge seen only once two later stages agree
		activity = (s.rx_s2 == s.rx_s3) & ~s.rx_s3 & s.rx_level;
		warn_now = (tec_i >= `CSF_WARN_LIMIT) | (rec_i >= `CSF_WARN_LIMIT);
	end

	// ==========================================================
	// next state
	always_comb begin
		next_s = s;
		store   = 1'b0;
		rel     = 1'b0;
		cnt_tmp = s.rx_count;
		next_s.ack       = req;
		next_s.err_reset = 1'b0;
		next_s.rx_s1     = can_rx_i;
		next_s.rx_s2     = s.rx_s1;
		next_s.rx_s3     = s.rx_s2;
		if (s.rx_s2 == s.rx_s3) begin
			next_s.rx_level = s.rx_s3;
		end
		next_s.sjw = {1'b0, s.timing[7:6]} + 3'd1;

		// register reads; the interrupt flags vanish on the acked read
		next_s.rdata = 8'h00;
		if (rd) begin
			case (idx)
				`CSF_IDX_CTRL: begin
					next_s.rdata = {1'b0, s.spd, 1'b0, s.overrun_irq_enable, s.error_irq_enable, s.tx_irq_enable, s.rx_irq_enable, s.halt};
				end
				`CSF_IDX_CMD: begin
					next_s.rdata = `CSF_CMD_READ;
				end
				`CSF_IDX_STAT: begin
					next_s.rdata = stat_byte;
				end
				`CSF_IDX_IRQ: begin
					next_s.rdata = irq_byte;
					next_s.wakeup_flag = 1'b0;
					next_s.overrun_irq_flag = 1'b0;
					next_s.error_irq_flag = 1'b0;
					next_s.tx_done_irq_flag = 1'b0;
					next_s.rx_irq_flag = 1'b0;
				end
				`CSF_IDX_PATT: begin
					next_s.rdata = s.halt ? s.patt : 8'h00;
				end
				`CSF_IDX_MASK: begin
					next_s.rdata = s.halt ? s.mask : 8'h00;
				end
				`CSF_IDX_TIMING: begin
					next_s.rdata = s.halt ? s.timing : 8'h00;
				end
				default: begin
					next_s.rdata = 8'h00;
				end
			endcase
		end

		// register writes; status and flag registers ignore writes
		if (wr) begin
			case (idx)
				`CSF_IDX_CTRL: begin
					next_s.halt = wbyte[`CSF_CTRL_HALT];
					next_s.rx_irq_enable  = wbyte[`CSF_CTRL_RIE];
					next_s.tx_irq_enable  = wbyte[`CSF_CTRL_TIE];
					next_s.error_irq_enable  = wbyte[`CSF_CTRL_EIE];
					next_s.overrun_irq_enable  = wbyte[`CSF_CTRL_OIE];
					next_s.spd  = wbyte[`CSF_CTRL_SPD];
				end
				`CSF_IDX_CMD: begin
					if (!s.halt) begin
						if (wbyte[`CSF_CMD_SEND] && s.tx_buffer_free) begin
							next_s.send_done_flag = 1'b0;
							next_s.tx_buffer_free = 1'b0;
							next_s.tx_pending = 1'b1;
						end
						if (wbyte[`CSF_CMD_ABORT] && s.tx_pending && !s.ts) begin
							next_s.tx_pending = 1'b0;
							next_s.tx_buffer_free = 1'b1;
							next_s.tx_done_irq_flag = next_s.tx_done_irq_flag | s.tx_irq_enable;
						end
						if (wbyte[`CSF_CMD_CLR_OVR]) begin
							next_s.ovr = 1'b0;
						end
						if (wbyte[`CSF_CMD_RELEASE]) begin
							rel = 1'b1;
							next_s.release_cmd = 1'b1;
						end
						if (wbyte[`CSF_CMD_SLEEP]) begin
							// busy or flagged: refuse sleep and wake at once
							if (s.ts || s.rs || (irq_byte != 8'h00)) begin
								next_s.wakeup_flag = 1'b1;
							end else begin
								next_s.sleep = 1'b1;
							end
						end else begin
							next_s.sleep = 1'b0;
						end
					end
				end
				`CSF_IDX_PATT: begin
					if (s.halt) begin
						next_s.patt = wbyte;
					end
				end
				`CSF_IDX_MASK: begin
					if (s.halt) begin
						next_s.mask = wbyte;
					end
				end
				`CSF_IDX_TIMING: begin
					if (s.halt) begin
						next_s.timing = wbyte;
					end
				end
				default: begin
				end
			endcase
		end

		// wake on a dominant edge while asleep
		if (s.sleep && activity) begin
			next_s.sleep = 1'b0;
			next_s.wakeup_flag   = 1'b1;
		end

		// receive buffers: release first, then store
		if (rel && (cnt_tmp != 2'd0)) begin
			cnt_tmp = cnt_tmp - 2'd1;
			next_s.rd_buf = ~s.rd_buf;
		end
		if (rel) begin
			next_s.rx_message_pending = (cnt_tmp != 2'd0);
		end

		if (s.phase == csf_pkg::CSF_RUN) begin
			if (tx_start_i) begin
				next_s.ts = 1'b1;
				next_s.rs = 1'b0;
				if (cnt_tmp == 2'd2) begin
					next_s.ovr = 1'b1;
					next_s.overrun_irq_flag = next_s.overrun_irq_flag | s.overrun_irq_enable;
				end
			end
			if (arb_lost_i) begin
				next_s.ts = 1'b0;
				next_s.rs = 1'b1;
			end
			if (rx_start_i && !s.ts && !s.rs) begin
				next_s.rs = 1'b1;
			end
			if (tx_done_i) begin
				next_s.ts  = 1'b0;
				next_s.send_done_flag = 1'b1;
				next_s.tx_buffer_free = 1'b1;
				next_s.tx_pending = 1'b0;
				next_s.tx_done_irq_flag = next_s.tx_done_irq_flag | s.tx_irq_enable;
			end
			if (rx_done_i) begin
				next_s.rs = 1'b0;
				// rejected frames leave the write buffer in place for reuse
				if (accept) begin
					if (cnt_tmp == 2'd2) begin
						next_s.ovr = 1'b1;
						next_s.overrun_irq_flag = next_s.overrun_irq_flag | s.overrun_irq_enable;
					end else begin
						store = 1'b1;
					end
				end
			end
		end

		if (store) begin
			cnt_tmp = cnt_tmp + 2'd1;
			next_s.wr_buf = ~s.wr_buf;
			if (!next_s.rx_message_pending) begin
				next_s.rx_message_pending = 1'b1;
				next_s.rx_irq_flag = next_s.rx_irq_flag | s.rx_irq_enable;
				next_s.release_cmd = 1'b0;
			end
		end
		next_s.rx_count = cnt_tmp;

		// error status and its interrupt
		next_s.warn = warn_now;
		if ((s.phase == csf_pkg::CSF_RUN) && tec_i >= `CSF_TEC_OFF) begin
			next_s.bus_off = 1'b1;
			next_s.halt    = 1'b1;
		end

		// controller phase
		case (s.phase)
			csf_pkg::CSF_RUN: begin
				if (next_s.halt) begin
					next_s.phase = csf_pkg::CSF_HALT;
				end
			end
			csf_pkg::CSF_HALT: begin
				if (!next_s.halt) begin
					next_s.phase = csf_pkg::CSF_WAIT;
					next_s.runs_left = s.bus_off ? `CSF_RUNS_BUSOFF : `CSF_RUNS_NORMAL;
				end
			end
			csf_pkg::CSF_WAIT: begin
				if (next_s.halt) begin
					next_s.phase = csf_pkg::CSF_HALT;
				end else if (run11_i) begin
					next_s.runs_left = s.runs_left - 8'd1;
					if (s.runs_left == 8'd1) begin
						next_s.phase = csf_pkg::CSF_RUN;
						if (s.bus_off) begin
							next_s.bus_off   = 1'b0;
							next_s.err_reset = 1'b1;
						end
					end
				end
			end
			default: begin
				next_s.phase = csf_pkg::CSF_HALT;
			end
		endcase

		// halt forces the non-error status to its idle pattern
		if (next_s.halt) begin
			next_s.ts  = 1'b0;
			next_s.rs  = 1'b0;
			next_s.send_done_flag = 1'b1;
			next_s.tx_buffer_free = 1'b1;
			next_s.ovr = 1'b0;
			next_s.rx_message_pending = 1'b0;
			next_s.tx_pending = 1'b0;
			next_s.rx_count   = 2'd0;
			next_s.overrun_irq_flag = 1'b0;
			next_s.tx_done_irq_flag = 1'b0;
			next_s.rx_irq_flag = 1'b0;
		end

		if ((next_s.warn != s.warn) || (next_s.bus_off != s.bus_off)) begin
			next_s.error_irq_flag = next_s.error_irq_flag | s.error_irq_enable;
		end

		// registered so the engine enable comes straight from a flop
		next_s.run = (next_s.phase == csf_pkg::CSF_RUN) & ~next_s.bus_off & ~next_s.sleep;
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.phase <= csf_pkg::CSF_HALT;
			s.halt  <= 1'b1;
			s.send_done_flag   <= 1'b1;
			s.tx_buffer_free   <= 1'b1;
			s.sjw   <= 3'd1;
			s.rx_s1 <= 1'b1;
			s.rx_s2 <= 1'b1;
			s.rx_s3 <= 1'b1;
			s.rx_level <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// outputs, all from flops
	always_comb begin
		dat_o           = {24'h000000, s.rdata};
		ack_o           = s.ack;
		halt_o          = s.halt;
		core_run_o      = s.run;
		err_cnt_reset_o = s.err_reset;
		tx_pending_o    = s.tx_pending;
		tx_buf_open_o   = s.tx_buffer_free;
		rx_wr_buf_o     = s.wr_buf;
		rx_rd_buf_o     = s.rd_buf;
		sleep_o         = s.sleep;
		both_edges_o    = s.spd;
		tq_pulse_o      = tq_bus.tq;
		sjw_o           = s.sjw;
	end

endmodule

`default_nettype wire

// >>> bench/csf_top_assertions.sv
// concurrent checks on the ports of the can status, filter and timing block
`include "csf_params.svh"
`timescale 1ns/1ps
`default_nettype none

module csf_top_assertions (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [9:0]  adr_i,
	input  wire logic [31:0] dat_o,
	input  wire logic        ack_o,
	// engine side
	input  wire logic [8:0]  tec_i,
	input  wire logic        can_rx_i,
	input  wire logic        halt_o,
	input  wire logic        core_run_o,
	input  wire logic        err_cnt_reset_o,
	input  wire logic        tx_pending_o,
	input  wire logic        tx_buf_open_o,
	input  wire logic        sleep_o,
	input  wire logic [2:0]  sjw_o
);
	// ==========================================================
	// common
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic rd_take = cyc_i && stb_i && !ack_o && !we_i;

	// ==========================================================
	// bus and register checks
	property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("request not answered next cycle");
	property p_ack_pulse; ack_o |=> !ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge held too long");
	property p_hi_zero; ack_o |-> dat_o[31:8] == 24'h0; endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("upper read bytes not zero");
	property p_cmd_ff; rd_take && adr_i[9:2] == `CSF_IDX_CMD |=> dat_o == 32'hff; endproperty
	a_cmd_ff: assert property (p_cmd_ff) else $error("command port read not all ones");
	property p_cfg_lock;
		rd_take && !halt_o && adr_i[9:2] inside {`CSF_IDX_PATT, `CSF_IDX_MASK, `CSF_IDX_TIMING}
			|=> dat_o == 32'h0;
	endproperty
	a_cfg_lock: assert property (p_cfg_lock) else $error("setup readable while running");
	property p_sjw; sjw_o inside {[3'h1:3'h4]}; endproperty
	a_sjw: assert property (p_sjw) else $error("jump width out of range");

	// ==========================================================
	// controller state checks
	property p_busoff; core_run_o && tec_i >= 9'd256 |=> halt_o && !core_run_o; endproperty
	a_busoff: assert property (p_busoff) else $error("no halt at bus-off");
	property p_halt_quiet; halt_o |-> !core_run_o; endproperty
	a_halt_quiet: assert property (p_halt_quiet) else $error("engine runs while halted");
	property p_lock; tx_pending_o |-> !tx_buf_open_o; endproperty
	a_lock: assert property (p_lock) else $error("buffer open while send pending");
	property p_recover; err_cnt_reset_o |-> !halt_o ##1 !err_cnt_reset_o; endproperty
	a_recover: assert property (p_recover) else $error("bad counter clear pulse");
	property p_wake; sleep_o && $fell(can_rx_i) |-> ##[1:8] !sleep_o; endproperty
	a_wake: assert property (p_wake) else $error("no wake on bus activity");

	c_recover: cover property (err_cnt_reset_o);
	c_wake: cover property (sleep_o ##1 !sleep_o);
	c_busoff: cover property (core_run_o ##1 halt_o);
endmodule

`default_nettype wire

// >>> bench/csf_bus_model.sv
// far side: other nodes as seen through the protocol engine, plus the receive line
`timescale 1ns/1ps
`default_nettype none

module csf_bus_model (
	// clock
	input  wire logic        clk_i,
	// engine events and counters
	output logic      [5:0]  ev_o,
	output logic      [10:0] id_o,
	output logic      [8:0]  tec_o,
	output logic      [8:0]  rec_o,
	// receive line, recessive high
	output logic             rx_o
);
	initial begin
		ev_o = 6'h0;
		id_o = 11'h2aa;
		tec_o = 9'h0;
		rec_o = 9'h0;
		rx_o = 1'b1;
	end

	// one-cycle event; identifier valid only alongside it
	task automatic pulse(input logic [5:0] m, input logic [10:0] id);
		@(posedge clk_i);
		ev_o <= m;
		id_o <= id;
		@(posedge clk_i);
		ev_o <= 6'h0;
		id_o <= ~id;
	endtask

	task automatic errs(input logic [8:0] t, input logic [8:0] r);
		@(posedge clk_i);
		tec_o <= t;
		rec_o <= r;
		repeat (2) @(posedge clk_i);
	endtask

	// a dominant start bit is the activity that wakes a sleeping node
	task automatic wake;
		@(posedge clk_i);
		rx_o <= 1'b0;
		repeat (3) @(posedge clk_i);
		rx_o <= 1'b1;
		repeat (6) @(posedge clk_i);
	endtask
endmodule

`default_nettype wire

// >>> bench/csf_top_tb.sv
// self-checking bench of the can status, filter and timing block
`include "csf_params.svh"
`timescale 1ns/1ps
`default_nettype none

module csf_top_tb;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i;
	logic [9:0]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i;
	wire  [31:0] dat_o;
	wire  [8:0]  tec_i, rec_i;
	wire  [10:0] rx_id_i;
	wire  [2:0]  sjw_o;
	wire         ack_o, halt_o, core_run_o, err_cnt_reset_o, tx_pending_o, tx_buf_open_o;
	wire         rx_wr_buf_o, rx_rd_buf_o, sleep_o, both_edges_o, tq_pulse_o, can_rx_i;
	wire         tx_start_i, tx_done_i, arb_lost_i, rx_start_i, rx_done_i, run11_i;
	int          fails, n_checks, seed, i, n;
	logic [7:0]  q, patt, mask;
	logic [10:0] id;

	csf_top dut (.*);
	csf_bus_model far (
		.clk_i (clk_i),
		.ev_o  ({run11_i, rx_done_i, rx_start_i, arb_lost_i, tx_done_i, tx_start_i}),
		.id_o  (rx_id_i),
		.tec_o (tec_i),
		.rec_o (rec_i),
		.rx_o  (can_rx_i)
	);

	// ==========================================================
	// helpers
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// classic cycle; ack and read data taken at the same rising edge, then released
	task automatic wb(input logic w, input logic [7:0] x, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {x, 2'h0};
		dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 20);
		if (k >= 20) chk(8'h0, 8'h1);
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask

	task automatic rdbit(input logic [7:0] x, input int b, input logic e);
		wb(1'h0, x, 8'h0);
		chk({7'h0, q[b]}, {7'h0, e});
	endtask

	function automatic logic hit(input logic [10:0] v);
		return ((v[10:3] ^ patt) & ~mask) == 8'h0;
	endfunction

	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ==========================================================
	// clock and watchdog
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	initial begin
		#200000;
		fails++;
		$display("unexpected at %0t: timeout", $time);
		report_and_stop;
	end

	// ==========================================================
	// scenarios
	initial begin
		seed = 84;
		fails = 0;
		n_checks = 0;
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 10'h0;
		sel_i = 4'h1;
		dat_i = 32'h0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'h1, `CSF_IDX_STAT, 8'hff);
		wb(1'h0, `CSF_IDX_STAT, 8'h0);
		chk(q, `CSF_STAT_RESET);
		wb(1'h0, `CSF_IDX_IRQ, 8'h0);
		chk(q, 8'h00);
		wb(1'h0, 8'h3f, 8'h0);
		chk(q, 8'h00);
		// setup only while halted
		patt = $random(seed);
		mask = $random(seed) & $random(seed) & 8'h7f;
		wb(1'h1, `CSF_IDX_PATT, patt);
		wb(1'h1, `CSF_IDX_MASK, mask);
		wb(1'h1, `CSF_IDX_TIMING, 8'h83);
		wb(1'h0, `CSF_IDX_MASK, 8'h0);
		chk(q, mask);
		chk({5'h0, sjw_o}, 8'h03);
		repeat (2) @(negedge clk_i);
		while (tq_pulse_o !== 1'b1) @(negedge clk_i);
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (tq_pulse_o !== 1'b1 && n < 99);
		chk(n[7:0], 8'h04);
		wb(1'h1, `CSF_IDX_CTRL, 8'h1e);
		far.pulse(6'h20, 11'h0);
		wb(1'h1, `CSF_IDX_PATT, ~patt);
		wb(1'h0, `CSF_IDX_PATT, 8'h0);
		chk(q, 8'h00);
		// random identifiers through the filter
		for (i = 0; i < 8; i++) begin
			id = $random(seed);
			if (i < 2) id[10:3] = patt;
			far.pulse(6'h08, id);
			rdbit(`CSF_IDX_STAT, `CSF_ST_RS, 1'b1);
			far.pulse(6'h10, id);
			rdbit(`CSF_IDX_STAT, `CSF_ST_RBS, hit(id));
			rdbit(`CSF_IDX_IRQ, `CSF_IRQ_RIF, hit(id));
			wb(1'h1, `CSF_IDX_CMD, 8'h04);
			rdbit(`CSF_IDX_STAT, `CSF_ST_RBS, 1'b0);
		end
		// third accepted frame with both buffers full
		id = {patt, 3'h5};
		repeat (3) far.pulse(6'h10, id);
		rdbit(`CSF_IDX_STAT, `CSF_ST_DO, 1'b1);
		rdbit(`CSF_IDX_IRQ, `CSF_IRQ_OIF, 1'b1);
		wb(1'h1, `CSF_IDX_CMD, 8'h0c);
		wb(1'h0, `CSF_IDX_STAT, 8'h0);
		chk(q & 8'h03, 8'h01);
		wb(1'h1, `CSF_IDX_CMD, 8'h04);
		// send with full buffers, lose arbitration, retry
		repeat (2) far.pulse(6'h10, id);
		wb(1'h1, `CSF_IDX_CMD, 8'h01);
		wb(1'h0, `CSF_IDX_STAT, 8'h0);
		chk(q & 8'h0c, 8'h00);
		chk({7'h0, tx_pending_o}, 8'h01);
		far.pulse(6'h01, 11'h0);
		rdbit(`CSF_IDX_STAT, `CSF_ST_DO, 1'b1);
		rdbit(`CSF_IDX_STAT, `CSF_ST_TS, 1'b1);
		far.pulse(6'h04, 11'h0);
		wb(1'h0, `CSF_IDX_STAT, 8'h0);
		chk(q & 8'h30, 8'h10);
		far.pulse(6'h10, {~patt, 3'h0});
		far.pulse(6'h01, 11'h0);
		far.pulse(6'h02, 11'h0);
		wb(1'h0, `CSF_IDX_STAT, 8'h0);
		chk(q & 8'h2c, 8'h0c);
		rdbit(`CSF_IDX_IRQ, `CSF_IRQ_TIF, 1'b1);
		wb(1'h1, `CSF_IDX_CMD, 8'h0c);
		wb(1'h1, `CSF_IDX_CMD, 8'h0c);
		// abort before the frame starts
		wb(1'h1, `CSF_IDX_CMD, 8'h01);
		wb(1'h1, `CSF_IDX_CMD, 8'h02);
		wb(1'h0, `CSF_IDX_STAT, 8'h0);
		chk(q & 8'h0c, 8'h04);
		// warning, bus-off and recovery
		far.errs(9'd0, 9'd96);
		rdbit(`CSF_IDX_STAT, `CSF_ST_ES, 1'b1);
		rdbit(`CSF_IDX_IRQ, `CSF_IRQ_EIF, 1'b1);
		far.errs(9'd256, 9'd96);
		wb(1'h0, `CSF_IDX_STAT, 8'h0);
		chk(q, 8'hcc);
		chk({7'h0, halt_o}, 8'h01);
		far.errs(9'd0, 9'd0);
		wb(1'h1, `CSF_IDX_CTRL, 8'h1e);
		repeat (127) far.pulse(6'h20, 11'h0);
		rdbit(`CSF_IDX_STAT, `CSF_ST_BS, 1'b1);
		far.pulse(6'h20, 11'h0);
		rdbit(`CSF_IDX_STAT, `CSF_ST_BS, 1'b0);
		// sleep, then woken by the bus
		wb(1'h0, `CSF_IDX_IRQ, 8'h0);
		wb(1'h1, `CSF_IDX_CMD, 8'h10);
		chk({7'h0, sleep_o}, 8'h01);
		far.wake;
		chk({7'h0, sleep_o}, 8'h00);
		rdbit(`CSF_IDX_IRQ, `CSF_IRQ_WIF, 1'b1);
		wb(1'h0, `CSF_IDX_IRQ, 8'h0);
		chk(q, 8'h00);
		report_and_stop;
	end
endmodule

bind csf_top csf_top_assertions u_chk (.*);

`default_nettype wire
